// *** src/fpdc_pkg.sv ***
// package: register map, field positions and timing constants for power-down control
package fpdc_pkg;
   localparam int unsigned CLK_HZ = 10_000_000;
   localparam logic [3:0] REG_PDN_ADDR = 4'h0;
   localparam logic [3:0] REG_REF1_ADDR = 4'h1;
   localparam logic [3:0] REG_REF3_ADDR = 4'h3;
   localparam logic [3:0] REG_STAT_ADDR = 4'h4;
   localparam int BIT_AMP_FAST = 0;
   localparam int BIT_AMP_FULL = 1;
   localparam int BIT_CONV_FAST = 2;
   localparam int BIT_CONV_FULL = 3;
   localparam int BIT_ATT_GAIN = 4;
   localparam int BIT_PREAMP = 5;
   localparam int BIT_REF1_EXT = 13;
   localparam int BIT_REF3_EXT = 15;
   localparam logic [15:0] REG_RESET_VAL = 16'h0000;
   localparam int unsigned AMP_WAKE_NS = 2000;
   localparam int unsigned CONV_WAKE_NS = 1000;
   localparam int unsigned ENTRY_MAX_NS = 1000;
   localparam int unsigned AMP_WAKE_CYC = (AMP_WAKE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int unsigned CONV_WAKE_CYC = (CONV_WAKE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int unsigned ENTRY_MAX_CYC = (ENTRY_MAX_NS * (CLK_HZ / 1_000_000)) / 1000;
   localparam int unsigned WAKE_PCT_DIV = 100;
   localparam int CNT_W = 24;
   localparam int NUM_CONV = 8;
   typedef enum logic [1:0] {
      FPDC_AWAKE = 2'b00,
      FPDC_ASLEEP = 2'b01,
      FPDC_WAKING = 2'b10
   } fpdc_wake_e;
endpackage : fpdc_pkg

// *** src/fpdc_power_ctrl.sv ***
// power-down combining, wake timing, reference select and sample clock fan-out
//
// Design decisions made here: the register addresses and the strobed register port.
`timescale 1ns/1ps
//Function
// - each block's power-down is the OR of every pin and register control covering it
// - global pin or either full-sleep bit switches everything off, references included
// - amplifier chain may sleep alone while converters and serial output keep running
// - configuration registers keep their contents through every power-down mode
// - partial sleep keeps references and serial frame and bit clocks running
// - partial sleep entered by chain or converter pins or fast-sleep bits
// - chain wakes after max of 2 us or 1% of sleep; converters after 1 us
// - power-down entry takes effect in under 1.0 us
// - external reference only when register 3 bit 15 and register 1 bit 13 set
// - one sampling clock feeds eight converters through equal-delay paths
module fpdc_power_ctrl
   import fpdc_pkg::*;
(
   input wire logic sys_clk_in,
   input wire logic rst_n_in,
   input wire logic global_sleep_pin_in,
   input wire logic amp_chain_sleep_pin_in,
   input wire logic converter_sleep_pin_in,
   input wire logic [3:0] addr_in,
   input wire logic [15:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [15:0] rdata_out,
   output logic preamp_off_out,
   output logic att_gain_off_out,
   output logic converter_off_out,
   output logic reference_off_out,
   output logic serial_clk_off_out,
   output logic amp_ready_out,
   output logic conv_ready_out,
   output logic ext_ref_out,
   output logic [NUM_CONV-1:0] conv_sample_clk_out
);
   logic [2:0] pin_s1_reg;
   logic [2:0] pin_s2_reg;
   logic [15:0] pdn_reg;
   logic [15:0] ref1_reg;
   logic [15:0] ref3_reg;
   logic glob_pd;
   logic amp_pd;
   logic conv_pd;
   logic full_pd;
   logic preamp_pd;
   logic att_pd;
   fpdc_wake_e amp_st_reg;
   fpdc_wake_e conv_st_reg;
   logic [CNT_W-1:0] amp_sleep_cnt_reg;
   logic [CNT_W-1:0] amp_wake_cnt_reg;
   logic [CNT_W-1:0] conv_wake_cnt_reg;
   logic [CNT_W-1:0] amp_wake_need;
   logic [CNT_W-1:0] pct_cyc;
   logic sample_clk_reg;

   // pins come from outside the clock domain
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         pin_s1_reg <= 3'h0;
         pin_s2_reg <= 3'h0;
      end else begin
         pin_s1_reg <= {converter_sleep_pin_in, amp_chain_sleep_pin_in, global_sleep_pin_in};
         pin_s2_reg <= pin_s1_reg;
      end
   end

   // register writes; contents never touched by power-down state
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         pdn_reg <= REG_RESET_VAL;
         ref1_reg <= REG_RESET_VAL;
         ref3_reg <= REG_RESET_VAL;
      end else if (wr_in) begin
         case (addr_in)
            REG_PDN_ADDR: pdn_reg <= wdata_in;
            REG_REF1_ADDR: ref1_reg <= wdata_in;
            REG_REF3_ADDR: ref3_reg <= wdata_in;
            default: ;
         endcase
      end
   end

   assign glob_pd = pin_s2_reg[0];
   assign full_pd = glob_pd | pdn_reg[BIT_AMP_FULL] | pdn_reg[BIT_CONV_FULL];
   assign amp_pd = full_pd | pin_s2_reg[1] | pdn_reg[BIT_AMP_FAST];
   assign conv_pd = full_pd | pin_s2_reg[2] | pdn_reg[BIT_CONV_FAST];
   assign preamp_pd = amp_pd | pdn_reg[BIT_PREAMP];
   assign att_pd = amp_pd | pdn_reg[BIT_ATT_GAIN];

   // outputs registered: one cycle entry from a register bit, three from a pin, well inside the entry limit
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         preamp_off_out <= 1'b0;
         att_gain_off_out <= 1'b0;
         converter_off_out <= 1'b0;
         reference_off_out <= 1'b0;
         serial_clk_off_out <= 1'b0;
         ext_ref_out <= 1'b0;
      end else begin
         preamp_off_out <= preamp_pd;
         att_gain_off_out <= att_pd;
         converter_off_out <= conv_pd;
         reference_off_out <= full_pd;
         serial_clk_off_out <= full_pd;
         ext_ref_out <= ref3_reg[BIT_REF3_EXT] & ref1_reg[BIT_REF1_EXT];
      end
   end

   // read port, data one cycle after the strobe
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         rdata_out <= 16'h0000;
      end else if (rd_in) begin
         case (addr_in)
            REG_PDN_ADDR: rdata_out <= pdn_reg;
            REG_REF1_ADDR: rdata_out <= ref1_reg;
            REG_REF3_ADDR: rdata_out <= ref3_reg;
            REG_STAT_ADDR: rdata_out <= {10'h000, ext_ref_out, conv_ready_out,
               amp_ready_out, converter_off_out, att_gain_off_out, preamp_off_out};
            default: rdata_out <= 16'h0000;
         endcase
      end else begin
         rdata_out <= 16'h0000;
      end
   end

   // wake time scales with sleep time; counter saturates rather than wraps
   assign pct_cyc = amp_sleep_cnt_reg / CNT_W'(WAKE_PCT_DIV);
   assign amp_wake_need = (pct_cyc > CNT_W'(AMP_WAKE_CYC)) ? pct_cyc : CNT_W'(AMP_WAKE_CYC);

   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         amp_st_reg <= FPDC_AWAKE;
         amp_sleep_cnt_reg <= '0;
         amp_wake_cnt_reg <= '0;
      end else if (amp_pd) begin
         amp_st_reg <= FPDC_ASLEEP;
         amp_wake_cnt_reg <= '0;
         if (amp_st_reg != FPDC_ASLEEP) begin
            amp_sleep_cnt_reg <= CNT_W'(1);
         end else if (amp_sleep_cnt_reg != '1) begin
            amp_sleep_cnt_reg <= amp_sleep_cnt_reg + CNT_W'(1);
         end
      end else begin
         case (amp_st_reg)
            FPDC_ASLEEP: begin
               amp_st_reg <= FPDC_WAKING;
               amp_wake_cnt_reg <= CNT_W'(1);
            end
            FPDC_WAKING: begin
               if (amp_wake_cnt_reg >= amp_wake_need) begin
                  amp_st_reg <= FPDC_AWAKE;
               end else begin
                  amp_wake_cnt_reg <= amp_wake_cnt_reg + CNT_W'(1);
               end
            end
            default: amp_st_reg <= FPDC_AWAKE;
         endcase
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         conv_st_reg <= FPDC_AWAKE;
         conv_wake_cnt_reg <= '0;
      end else if (conv_pd) begin
         conv_st_reg <= FPDC_ASLEEP;
         conv_wake_cnt_reg <= '0;
      end else begin
         case (conv_st_reg)
            FPDC_ASLEEP: begin
               conv_st_reg <= FPDC_WAKING;
               conv_wake_cnt_reg <= CNT_W'(1);
            end
            FPDC_WAKING: begin
               if (conv_wake_cnt_reg >= CNT_W'(CONV_WAKE_CYC)) begin
                  conv_st_reg <= FPDC_AWAKE;
               end else begin
                  conv_wake_cnt_reg <= conv_wake_cnt_reg + CNT_W'(1);
               end
            end
            default: conv_st_reg <= FPDC_AWAKE;
         endcase
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         amp_ready_out <= 1'b0;
         conv_ready_out <= 1'b0;
      end else begin
         amp_ready_out <= (amp_st_reg == FPDC_AWAKE) & ~amp_pd;
         conv_ready_out <= (conv_st_reg == FPDC_AWAKE) & ~conv_pd;
      end
   end

   // sample clock: divided from sys_clk; host must run it long before use
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         sample_clk_reg <= 1'b0;
      end else begin
         sample_clk_reg <= ~sample_clk_reg;
      end
   end

   // identical flop per converter keeps every branch the same depth
   genvar gi;
   generate
      for (gi = 0; gi < NUM_CONV; gi++) begin : g_tree
         always_ff @(posedge sys_clk_in) begin
            if (!rst_n_in) begin
               conv_sample_clk_out[gi] <= 1'b0;
            end else begin
               conv_sample_clk_out[gi] <= sample_clk_reg;
            end
         end
      end
   endgenerate

   property entry_fast_p;
      @(posedge sys_clk_in) disable iff (!rst_n_in)
         $rose(amp_pd) |-> ##[1:10] att_gain_off_out;
   endproperty
   entry_time_a: assert property (entry_fast_p) else $error("entry too slow");

   full_ref_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      full_pd |=> reference_off_out && converter_off_out && preamp_off_out)
      else $error("full sleep left blocks on");

   amp_alone_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      (amp_pd && !conv_pd) |=> !converter_off_out && !serial_clk_off_out)
      else $error("converter hit by chain sleep");

   or_combine_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      (pin_s2_reg[1] || pdn_reg[BIT_AMP_FAST]) |=> preamp_off_out && att_gain_off_out)
      else $error("chain control ignored");

   stage_only_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      (pdn_reg[BIT_PREAMP] && !amp_pd && !pdn_reg[BIT_ATT_GAIN]) |=> !att_gain_off_out)
      else $error("preamp bit hit attenuator");

   partial_keep_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      (amp_pd && !full_pd) |=> !reference_off_out && !serial_clk_off_out)
      else $error("partial sleep killed refs");

   regs_kept_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      (!wr_in && full_pd) |=> $stable(ref1_reg) && $stable(ref3_reg) && $stable(pdn_reg))
      else $error("register lost in sleep");

   sequence conv_release_s;
      conv_pd ##1 !conv_pd;
   endsequence
   conv_wake_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      conv_release_s ##1 (!conv_pd) [*8] |-> ##[1:4] conv_ready_out)
      else $error("converter wake wrong");

   sequence amp_release_s;
      amp_pd ##1 !amp_pd;
   endsequence
   amp_min_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      amp_release_s |-> !amp_ready_out [*8])
      else $error("chain woke too early");

   ext_ref_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      ext_ref_out |-> $past(ref3_reg[BIT_REF3_EXT]) && $past(ref1_reg[BIT_REF1_EXT]))
      else $error("external reference wrongly set");

   tree_match_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      conv_sample_clk_out == {NUM_CONV{conv_sample_clk_out[0]}})
      else $error("sample clocks skewed");

   conv_fast_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      (pin_s2_reg[2] || pdn_reg[BIT_CONV_FAST]) |=> converter_off_out)
      else $error("converter partial sleep ignored");

   full_rest_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      full_pd |=> serial_clk_off_out && att_gain_off_out)
      else $error("full sleep left clocks on");

   att_only_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      (pdn_reg[BIT_ATT_GAIN] && !amp_pd && !conv_pd && !pdn_reg[BIT_PREAMP])
      |=> att_gain_off_out && !preamp_off_out && !converter_off_out)
      else $error("stage bit spread to other blocks");

   amp_drop_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      amp_pd |=> !amp_ready_out)
      else $error("chain ready held in sleep");

   conv_drop_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      conv_pd |=> !conv_ready_out)
      else $error("converter ready held in sleep");

   conv_min_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      conv_release_s |-> !conv_ready_out [*8])
      else $error("converter woke too early");

   ext_on_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      (ref3_reg[BIT_REF3_EXT] && ref1_reg[BIT_REF1_EXT]) |=> ext_ref_out)
      else $error("external reference not taken");

   read_keep_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      (rd_in && addr_in == REG_REF3_ADDR) |=> rdata_out == $past(ref3_reg))
      else $error("stored value read back wrong");
endmodule : fpdc_power_ctrl

// *** testbench/fpdc_host_model.sv ***
// host controller model: sleep pins and register bus master
`timescale 1ns/1ps
module fpdc_host_model (
   input wire logic sys_clk_in,
   input wire logic [15:0] rdata_in,
   output logic global_sleep_pin_out,
   output logic amp_chain_sleep_pin_out,
   output logic converter_sleep_pin_out,
   output logic [3:0] addr_out,
   output logic [15:0] wdata_out,
   output logic wr_out,
   output logic rd_out
);
   initial begin
      global_sleep_pin_out = 1'b0;
      amp_chain_sleep_pin_out = 1'b0;
      converter_sleep_pin_out = 1'b0;
      addr_out = 4'h0;
      wdata_out = 16'h0000;
      wr_out = 1'b0;
      rd_out = 1'b0;
   end
   // released bus lines show inverted data so stale values never pass
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge sys_clk_in);
      addr_out <= a;
      wdata_out <= d;
      wr_out <= 1'b1;
      @(posedge sys_clk_in);
      wr_out <= 1'b0;
      wdata_out <= ~d;
   endtask : wr
   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge sys_clk_in);
      addr_out <= a;
      rd_out <= 1'b1;
      @(posedge sys_clk_in);
      rd_out <= 1'b0;
      addr_out <= ~a;
      #1;
      d = rdata_in;
   endtask : rd
   task automatic pins(input logic [2:0] p);
      @(posedge sys_clk_in);
      {global_sleep_pin_out, amp_chain_sleep_pin_out, converter_sleep_pin_out} <= p;
   endtask : pins
   // sampling clock runs 50 us before normal operation is expected
   task automatic settle();
      repeat (500) @(posedge sys_clk_in);
   endtask : settle
endmodule : fpdc_host_model

// *** testbench/frontend_power_down_control_tb.sv ***
// self-checking bench for power-down control
`timescale 1ns/1ps
module frontend_power_down_control_tb;
   import fpdc_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic gp, ap, cp, wr, rd, pre, att, conv, refo, sclk, ardy, crdy, ext;
   logic [3:0] addr;
   logic [15:0] wd, rdat, d;
   logic [7:0] sc, sc0;
   logic [4:0] offs;
   int fail_count = 0;
   int n_checks = 0;
   int n, lim;
   localparam int LONG_SLEEP = 3000;
   logic [5:0] bits [8] = '{6'h01, 6'h02, 6'h04, 6'h08, 6'h10, 6'h20, 6'h30, 6'h00};
   logic [4:0] want [8] = '{5'h18, 5'h1F, 5'h04, 5'h1F, 5'h08, 5'h10, 5'h18, 5'h00};
   logic [4:0] pwant [3] = '{5'h1F, 5'h18, 5'h04};
   always #50 clk = ~clk;
   assign offs = {pre, att, conv, refo, sclk};
   fpdc_host_model host_u (
      .sys_clk_in(clk),
      .rdata_in(rdat),
      .global_sleep_pin_out(gp),
      .amp_chain_sleep_pin_out(ap),
      .converter_sleep_pin_out(cp),
      .addr_out(addr),
      .wdata_out(wd),
      .wr_out(wr),
      .rd_out(rd)
   );
   fpdc_power_ctrl dut_u (
      .sys_clk_in(clk),
      .rst_n_in(rst_n),
      .global_sleep_pin_in(gp),
      .amp_chain_sleep_pin_in(ap),
      .converter_sleep_pin_in(cp),
      .addr_in(addr),
      .wdata_in(wd),
      .wr_in(wr),
      .rd_in(rd),
      .rdata_out(rdat),
      .preamp_off_out(pre),
      .att_gain_off_out(att),
      .converter_off_out(conv),
      .reference_off_out(refo),
      .serial_clk_off_out(sclk),
      .amp_ready_out(ardy),
      .conv_ready_out(crdy),
      .ext_ref_out(ext),
      .conv_sample_clk_out(sc)
   );
   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : stop_test
   task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
      n_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch at %0t: %s seen %h want %h", $time, msg, seen, exp);
      end
   endtask : check
   // bounded wait; running out ends the run as a failure
   task automatic wait_ready(input int s, output int k);
      k = 0;
      while ((s ? crdy : ardy) !== 1'b1 && k < 200) begin
         @(posedge clk);
         #1;
         k++;
      end
      if (k >= 200) begin
         fail_count++;
         stop_test();
      end
   endtask : wait_ready
   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      #1;
      check({11'h0, offs}, 16'h0000, "reset offs");
      host_u.settle();
      check({14'h0, ardy, crdy}, 16'h0003, "ready");
      host_u.rd(REG_PDN_ADDR, d);
      check(d, REG_RESET_VAL, "reg0 reset");
      for (int i = 0; i < 8; i++) begin
         host_u.wr(REG_PDN_ADDR, {10'h0, bits[i]});
         @(posedge clk);
         #1;
         check({11'h0, offs}, {11'h0, want[i]}, "offs");
         host_u.rd(REG_PDN_ADDR, d);
         check(d, {10'h0, bits[i]}, "readback");
      end
      $display("test table done");
      host_u.settle();
      // third pass sleeps long enough for the 1% term to outgrow the 2 us floor
      for (int s = 0; s < 3; s++) begin
         lim = (s == 1) ? CONV_WAKE_CYC : ((s == 2) ? LONG_SLEEP / WAKE_PCT_DIV : AMP_WAKE_CYC);
         host_u.wr(REG_PDN_ADDR, (s == 1) ? 16'h0004 : 16'h0001);
         repeat ((s == 2) ? LONG_SLEEP : 8) @(posedge clk);
         host_u.wr(REG_PDN_ADDR, 16'h0000);
         wait_ready(s == 1, n);
         check({15'h0, n >= lim && n <= lim + 5}, 16'h0001, "wake time");
      end
      $display("test wake done");
      for (int p = 0; p < 3; p++) begin
         host_u.pins(3'b100 >> p);
         n = 0;
         while (offs !== pwant[p] && n < ENTRY_MAX_CYC) begin
            @(posedge clk);
            #1;
            n++;
         end
         check({11'h0, offs}, {11'h0, pwant[p]}, "pin offs");
         if (p == 1) begin
            sc0 = sc;
            @(posedge clk);
            #1;
            check({8'h0, sc}, {8'h0, ~sc0}, "sample clk toggles");
            check({8'h0, sc}, {8'h0, {8{sc[0]}}}, "sample clk matched");
         end
      end
      $display("test pins done");
      // references selected while fully asleep; contents must survive
      host_u.pins(3'b100);
      host_u.wr(REG_REF1_ADDR, 16'h0001 << BIT_REF1_EXT);
      host_u.rd(REG_REF1_ADDR, d);
      check({15'h0, ext}, 16'h0000, "one ref bit");
      host_u.wr(REG_REF3_ADDR, 16'h0001 << BIT_REF3_EXT);
      host_u.rd(REG_REF3_ADDR, d);
      check(d, 16'h0001 << BIT_REF3_EXT, "ref3 kept");
      check({15'h0, ext}, 16'h0001, "ext ref");
      host_u.wr(REG_REF1_ADDR, 16'h0000);
      host_u.rd(4'hF, d);
      check(d, 16'h0000, "unmapped read");
      check({15'h0, ext}, 16'h0000, "ref dropped");
      host_u.pins(3'b000);
      $display("test reference done");
      // mid-run reset clears the registers; ready returns without a wake delay
      repeat (4) @(posedge clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      check({8'h0, offs, ardy, crdy, ext}, 16'h0000, "outputs in reset");
      @(posedge clk);
      rst_n <= 1'b1;
      host_u.rd(REG_REF3_ADDR, d);
      check(d, REG_RESET_VAL, "ref3 after reset");
      check({14'h0, ardy, crdy}, 16'h0003, "ready after reset");
      host_u.rd(REG_STAT_ADDR, d);
      check(d, 16'h0018, "status awake");
      $display("test reset done");
      stop_test();
   end
endmodule : frontend_power_down_control_tb
